// ### pkg/bpg_defs.vh
`ifndef BPG_DEFS_VH
`define BPG_DEFS_VH
// register indices (printed offsets are not all multiples of four)
`define BPG_IDX_BYTECNT 8'h71
`define BPG_IDX_STATCTL 8'h72
`define BPG_IDX_PKTLEN 8'h7B
`define BPG_IDX_GAPLEN 8'h7C
`define BPG_IDX_CONFIG 8'h80
`define BPG_IDX_IRQSTAT 8'h81
`define BPG_IDX_IRQEN 8'h82
`define BPG_IDX_IRQCLR 8'h83
`define BPG_IDX_PKTCNT 8'h84
// field positions
`define BPG_LOCK_BIT 0
`define BPG_LOCKCLR_BIT 1
`define BPG_BYTEOVF_BIT 9
`define BPG_PKTOVF_BIT 10
`define BPG_CFG_GENEN_BIT 0
`define BPG_CFG_CHKEN_BIT 1
`define BPG_CFG_MODE_BIT 2
// reset values
`define BPG_PKTLEN_RST 16'h05DC
`define BPG_GAPLEN_RST 8'h7D
`define BPG_CONFIG_RST 3'h0
// generator timing
`define BPG_PREAMBLE_NIBBLES 5'h0D
`define BPG_PREAMBLE_NIB 4'h5
`define BPG_SFD_BYTE 8'hD5
`define BPG_GAP_STEP_SHIFT 2
`define BPG_LFSR_SEED 8'hFF
`endif

// ### rtl/bpg_prbs_step.v
`timescale 1ns/10ps
// next byte of the x^8+x^6+x^5+x^4+1 sequence, one bit per lfsr step
module bpg_prbs_step (
	// current state
	input wire [7:0] stateIn,
	// eight steps later
	output wire [7:0] stateOut
);
	wire [7:0] chain [0:8]; // intermediate states
	assign chain[0] = stateIn;
	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1) begin : step
			// galois-free fibonacci shift, feedback from the taps
			assign chain[i+1] = {chain[i][6:0], chain[i][7] ^ chain[i][5] ^ chain[i][4] ^ chain[i][3]};
		end
	endgenerate
	assign stateOut = chain[8];
endmodule

// ### rtl/bpg_selftest.v
`timescale 1ns/10ps
`include "bpg_defs.vh"
// Function
// - 8-bit error byte counter in status bits 7:0
// - writing bit 0 freezes counter snapshot
// - writing bit 1 locks and clears counters
// - packet counter overflow sets bit 10
// - byte counter overflow sets bit 9
// - overflow flags held until lock-and-clear
// - 16-bit packet length, resets to 1500
// - thirteen 0x5 nibbles then 0xD5 delimiter
// - 8-bit gap field, resets to 0x7D
// - gap bytes equal four times field, two for a zero field
// - 16-bit received byte count, lockable, saturating
module bpg_selftest (
	// clock and reset
	input wire ref_clk,
	input wire rst_n,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// generated byte stream toward the line
	output reg txValid_reg,
	output reg [7:0] txData_reg,
	output reg txFrame_reg,
	// received byte stream, same clock, no synchroniser needed
	input wire rxValid,
	input wire [7:0] rxData,
	input wire rxFrame,
	// interrupt
	output reg irq_reg
);
	localparam ST_IDLE = 2'h0; // generator waiting
	localparam ST_PRE = 2'h1; // preamble and delimiter
	localparam ST_DATA = 2'h2; // payload bytes
	localparam ST_GAP = 2'h3; // idle gap
	// configuration
	reg [15:0] pktLen_reg; // generated_packet_length
	reg [7:0] gapLen_reg; // inter_packet_gap_length
	reg [2:0] config_reg; // enables and counting_mode_setting
	reg [2:0] irqEn_reg; // interrupt enables
	reg [2:0] irqStat_reg; // sticky events
	// checker
	reg [7:0] errCnt_reg; // error_byte_counter live
	reg [15:0] byteCnt_reg; // received_byte_counter live
	reg [15:0] pktCnt_reg; // received packets live
	reg [7:0] errSnap_reg; // locked copies read by software
	reg [15:0] byteSnap_reg;
	reg [15:0] pktSnap_reg;
	reg byteOvf_reg; // byte_count_overflow_flag
	reg pktOvf_reg; // packet_count_overflow_flag
	reg [7:0] rxLfsr_reg; // checker prediction
	reg rxSynced_reg; // first byte seeds the predictor
	reg rxFramePrev_reg; // for frame end detection
	// generator
	reg [1:0] state_reg;
	reg [15:0] cnt_reg; // byte or nibble position
	reg [7:0] txLfsr_reg;
	wire [7:0] txLfsrNext;
	wire [7:0] rxLfsrNext;
	wire [7:0] rxSeedNext;
	// apb decode
	wire [9:0] wordIdx = paddr[11:2];
	wire acc = psel & penable & pready;
	wire wrStb = acc & pwrite;
	wire rdStb = acc & ~pwrite;
	wire wrStat = wrStb & (wordIdx == {2'h0, `BPG_IDX_STATCTL});
	wire lockCmd = wrStat & (pwdata[`BPG_LOCK_BIT] | pwdata[`BPG_LOCKCLR_BIT]);
	wire clrCmd = wrStat & pwdata[`BPG_LOCKCLR_BIT];
	wire satMode = ~config_reg[`BPG_CFG_MODE_BIT];
	// checker byte events
	wire rxByte = rxValid & config_reg[`BPG_CFG_CHKEN_BIT];
	wire rxErr = rxByte & rxSynced_reg & (rxData != rxLfsr_reg);
	wire pktEnd = rxFramePrev_reg & ~rxFrame & config_reg[`BPG_CFG_CHKEN_BIT];
	wire byteWrap = rxByte & (byteCnt_reg == 16'hFFFF);
	wire pktWrap = pktEnd & (pktCnt_reg == 16'hFFFF);
	wire errWrap = rxErr & (errCnt_reg == 8'hFF);
	wire [2:0] evt = {errWrap, pktWrap, byteWrap};
	wire [15:0] gapBytes = {6'h00, gapLen_reg, 2'h0};
	wire genEn = config_reg[`BPG_CFG_GENEN_BIT];

	bpg_prbs_step txStep (
		.stateIn(txLfsr_reg),
		.stateOut(txLfsrNext)
	);
	bpg_prbs_step rxStep (
		.stateIn(rxLfsr_reg),
		.stateOut(rxLfsrNext)
	);
	bpg_prbs_step rxSeed (
		.stateIn(rxData),
		.stateOut(rxSeedNext)
	);

	// apb handshake: one wait state so every access answers on the second access cycle
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pready <= 1'b0;
		end else begin
			pready <= psel & penable & ~pready;
		end
	end

	// configuration writes
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pktLen_reg <= `BPG_PKTLEN_RST;
			gapLen_reg <= `BPG_GAPLEN_RST;
			config_reg <= `BPG_CONFIG_RST;
			irqEn_reg <= 3'h0;
		end else if (wrStb) begin
			case (wordIdx)
				{2'h0, `BPG_IDX_PKTLEN}: pktLen_reg <= pwdata[15:0];
				{2'h0, `BPG_IDX_GAPLEN}: gapLen_reg <= pwdata[7:0];
				{2'h0, `BPG_IDX_CONFIG}: config_reg <= pwdata[2:0];
				{2'h0, `BPG_IDX_IRQEN}: irqEn_reg <= pwdata[2:0];
				default: begin
					// other writes steer nothing here
				end
			endcase
		end
	end

	// sticky events: a new event wins over a clear in the same cycle
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			irqStat_reg <= 3'h0;
			irq_reg <= 1'b0;
		end else begin
			if (wrStb && wordIdx == {2'h0, `BPG_IDX_IRQCLR}) begin
				irqStat_reg <= (irqStat_reg & ~pwdata[2:0]) | evt;
			end else begin
				irqStat_reg <= irqStat_reg | evt;
			end
			irq_reg <= |(irqStat_reg & irqEn_reg);
		end
	end

	// read mux, registered; unmapped reads return zero without error
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			pslverr <= 1'b0;
			if (psel & penable & ~pready & ~pwrite) begin
				case (wordIdx)
					{2'h0, `BPG_IDX_BYTECNT}: prdata <= {16'h0000, byteSnap_reg};
					{2'h0, `BPG_IDX_STATCTL}: prdata <= {21'h000000, pktOvf_reg, byteOvf_reg,
						1'b0, errSnap_reg};
					{2'h0, `BPG_IDX_PKTLEN}: prdata <= {16'h0000, pktLen_reg};
					{2'h0, `BPG_IDX_GAPLEN}: prdata <= {24'h000000, gapLen_reg};
					{2'h0, `BPG_IDX_CONFIG}: prdata <= {29'h00000000, config_reg};
					{2'h0, `BPG_IDX_IRQSTAT}: prdata <= {29'h00000000, irqStat_reg};
					{2'h0, `BPG_IDX_IRQEN}: prdata <= {29'h00000000, irqEn_reg};
					{2'h0, `BPG_IDX_PKTCNT}: prdata <= {16'h0000, pktSnap_reg};
					default: prdata <= 32'h00000000;
				endcase
			end
		end
	end

	// checker counters; the clear takes priority over same-cycle counting
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			errCnt_reg <= 8'h00;
			byteCnt_reg <= 16'h0000;
			pktCnt_reg <= 16'h0000;
			byteOvf_reg <= 1'b0;
			pktOvf_reg <= 1'b0;
		end else if (clrCmd) begin
			errCnt_reg <= 8'h00;
			byteCnt_reg <= 16'h0000;
			pktCnt_reg <= 16'h0000;
			byteOvf_reg <= 1'b0;
			pktOvf_reg <= 1'b0;
		end else begin
			if (rxErr && !(satMode && errCnt_reg == 8'hFF)) begin
				errCnt_reg <= errCnt_reg + 8'h01;
			end
			if (rxByte && !(satMode && byteCnt_reg == 16'hFFFF)) begin
				byteCnt_reg <= byteCnt_reg + 16'h0001;
			end
			if (pktEnd && !(satMode && pktCnt_reg == 16'hFFFF)) begin
				pktCnt_reg <= pktCnt_reg + 16'h0001;
			end
			// flags stick until the lock-and-clear command
			if (byteWrap) begin
				byteOvf_reg <= 1'b1;
			end
			if (pktWrap) begin
				pktOvf_reg <= 1'b1;
			end
		end
	end

	// snapshot taken on either lock command; software reads only the frozen copy
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			errSnap_reg <= 8'h00;
			byteSnap_reg <= 16'h0000;
			pktSnap_reg <= 16'h0000;
		end else if (lockCmd) begin
			errSnap_reg <= errCnt_reg;
			byteSnap_reg <= byteCnt_reg;
			pktSnap_reg <= pktCnt_reg;
		end
	end

	// predictor: first byte of each frame seeds it, later bytes are compared
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rxLfsr_reg <= `BPG_LFSR_SEED;
			rxSynced_reg <= 1'b0;
			rxFramePrev_reg <= 1'b0;
		end else begin
			rxFramePrev_reg <= rxFrame;
			if (!rxFrame) begin
				rxSynced_reg <= 1'b0;
			end else if (rxByte) begin
				rxSynced_reg <= 1'b1;
				// reseeding each frame keeps one lost byte from poisoning later frames
				rxLfsr_reg <= rxSynced_reg ? rxLfsrNext : rxSeedNext;
			end
		end
	end

	// generator: preamble nibbles, payload, gap
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			cnt_reg <= 16'h0000;
			txLfsr_reg <= `BPG_LFSR_SEED;
			txValid_reg <= 1'b0;
			txData_reg <= 8'h00;
			txFrame_reg <= 1'b0;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					txValid_reg <= 1'b0;
					txFrame_reg <= 1'b0;
					cnt_reg <= 16'h0000;
					if (genEn && pktLen_reg != 16'h0000) begin
						state_reg <= ST_PRE;
					end
				end
				ST_PRE: begin
					// thirteen nibbles go out as low nibbles, then the delimiter byte
					txValid_reg <= 1'b1;
					txFrame_reg <= 1'b1;
					if (cnt_reg < {11'h000, `BPG_PREAMBLE_NIBBLES}) begin
						txData_reg <= {4'h0, `BPG_PREAMBLE_NIB};
						cnt_reg <= cnt_reg + 16'h0001;
					end else begin
						txData_reg <= `BPG_SFD_BYTE;
						cnt_reg <= 16'h0000;
						state_reg <= ST_DATA;
					end
				end
				ST_DATA: begin
					txData_reg <= txLfsr_reg;
					txLfsr_reg <= txLfsrNext;
					if (cnt_reg == pktLen_reg - 16'h0001) begin
						cnt_reg <= 16'h0000;
						state_reg <= ST_GAP;
					end else begin
						cnt_reg <= cnt_reg + 16'h0001;
					end
				end
				ST_GAP: begin
					// the idle cycle that follows counts as part of the gap, so exit one early
					// limitation: a field of zero still leaves two idle cycles between frames
					txValid_reg <= 1'b0;
					txFrame_reg <= 1'b0;
					if (cnt_reg + 16'h0002 >= gapBytes) begin
						state_reg <= ST_IDLE;
					end else begin
						cnt_reg <= cnt_reg + 16'h0001;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end
endmodule

// ### tb/bpg_loop_model.sv
`timescale 1ns/10ps
// loopback: returns only payload bytes, two cycles late
module bpg_loop_model (
	// clock, reset
	input wire ref_clk,
	input wire rst_n,
	// generated stream
	input wire txValid,
	input wire [7:0] txData,
	input wire txFrame,
	// spoil the last byte of each frame
	input wire corrupt,
	// returned stream
	output logic rxValid,
	output logic [7:0] rxData,
	output logic rxFrame
);
	logic inPay; // past the delimiter
	logic dValid; // delay stage, so the last byte is known
	logic [7:0] dData;
	// idle data line toggles, never repeats a stale byte
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			inPay <= 1'b0;
			dValid <= 1'b0;
			dData <= 8'h00;
			rxValid <= 1'b0;
			rxData <= 8'h00;
			rxFrame <= 1'b0;
		end else begin
			inPay <= txFrame && (inPay || (txValid && txData == 8'hD5));
			dValid <= txValid && inPay;
			dData <= txData;
			rxValid <= dValid;
			rxData <= dValid ? dData ^ {8{corrupt && !txFrame}} : ~rxData;
			rxFrame <= dValid;
		end
	end
endmodule

// ### tb/bpg_selftest_chk.sv
`timescale 1ns/10ps
// pin-level checks of the register port and the stream
module bpg_selftest_chk (
	// clock, reset
	input wire ref_clk,
	input wire rst_n,
	// apb
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	// stream
	input wire txValid_reg,
	input wire [7:0] txData_reg,
	input wire txFrame_reg
);
	wire rd = psel && penable && pready && !pwrite; // read ends now
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	a_one_wait: assert property (psel && penable && !pready |=> pready) else $error("late");
	a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
	a_no_slverr: assert property (pready |-> !pslverr) else $error("slave error");
	a_pre_sfd: assert property ($rose(txFrame_reg) |-> (txData_reg == 8'h05) [*8] ##1
		(txData_reg == 8'h05) [*5] ##1 txData_reg == 8'hD5) else $error("bad preamble");
	a_valid_frame: assert property (txValid_reg == txFrame_reg) else $error("stray byte");
	a_gap_min: assert property ($fell(txFrame_reg) |=> !txFrame_reg) else $error("no gap");
	a_stat_rsvd: assert property (rd && paddr == 12'h1C8 |-> prdata[31:11] == 0 && !prdata[8])
		else $error("status reserved");
	a_gap_rsvd: assert property (rd && paddr == 12'h1F0 |-> prdata[31:8] == 0)
		else $error("gap reserved");
	a_unmapped: assert property (rd && paddr == 12'h100 |-> prdata == 0) else $error("unmapped");
endmodule
bind bpg_selftest bpg_selftest_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .txValid_reg(txValid_reg), .txData_reg(txData_reg),
	.txFrame_reg(txFrame_reg));

// ### tb/test_bist_packet_gen_checker.sv
`timescale 1ns/10ps
`include "bpg_defs.vh"
// registers over apb, stream looped back through the partner
module test_bist_packet_gen_checker;
	logic ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, corrupt = 0, rfPrev = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0;
	logic [31:0] expQ[$]; // expected read words, oldest first
	logic [15:0] pktLen;
	wire [31:0] prdata;
	wire [7:0] txData, rxData;
	wire pready, pslverr, txValid, txFrame, rxValid, rxFrame, irq;
	int num_errors = 0, n_checks = 0, nBy = 0, nPk = 0, n, m, seed = 32'hB050;
	initial forever #5 ref_clk = ~ref_clk;
	bpg_selftest u_bpg_selftest (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .txValid_reg(txValid), .txData_reg(txData),
		.txFrame_reg(txFrame), .rxValid(rxValid), .rxData(rxData), .rxFrame(rxFrame),
		.irq_reg(irq));
	bpg_loop_model u_bpg_loop_model (.ref_clk(ref_clk), .rst_n(rst_n), .txValid(txValid),
		.txData(txData), .txFrame(txFrame), .corrupt(corrupt), .rxValid(rxValid),
		.rxData(rxData), .rxFrame(rxFrame));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one transfer by register index; a read leaves its note
	task automatic apb(input logic [7:0] i, input logic w, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'b00, i, 2'b00};
		pwdata <= d;
		if (!w) expQ.push_back(d);
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (!pready);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// waits for k more looped frames; returns inside the gap
	task automatic waitPk(input int k);
		int t;
		t = nPk + k;
		while (nPk < t) @(posedge ref_clk);
	endtask
	// read monitor and loopback counters
	always @(posedge ref_clk) begin
		if (psel && penable && pready && !pwrite) chk(prdata, expQ.pop_front());
		if (rxValid) nBy++;
		if (rfPrev && !rxFrame) nPk++;
		rfPrev <= rxFrame;
	end
	task automatic finish_test;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (95000) @(posedge ref_clk);
		num_errors++;
		finish_test;
	end
	initial begin
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
		corrupt <= 1'b1;
		pktLen = 16'h0004 + 16'($random(seed) & 3);
		apb(`BPG_IDX_PKTLEN, 0, 32'h05DC);
		apb(`BPG_IDX_GAPLEN, 0, 32'h007D);
		apb(`BPG_IDX_STATCTL, 0, 32'h0);
		apb(8'h40, 0, 32'h0);
		apb(`BPG_IDX_IRQEN, 1, 32'h7);
		apb(`BPG_IDX_PKTLEN, 1, {16'h0000, pktLen});
		apb(`BPG_IDX_GAPLEN, 1, 32'h1);
		apb(`BPG_IDX_CONFIG, 1, 32'h3);
		do @(posedge ref_clk); while (!txFrame);
		for (n = 0; txFrame; n++) @(posedge ref_clk);
		for (m = 0; !txFrame; m++) @(posedge ref_clk);
		chk(n, 14 + pktLen);
		chk(m, 4);
		waitPk(300);
		apb(`BPG_IDX_STATCTL, 1, 32'h1);
		apb(`BPG_IDX_STATCTL, 0, 32'hFF);
		apb(`BPG_IDX_BYTECNT, 0, nBy);
		apb(`BPG_IDX_IRQSTAT, 0, 32'h4);
		corrupt <= 1'b0;
		waitPk(2);
		apb(`BPG_IDX_IRQEN, 1, 32'h0);
		repeat (2) @(posedge ref_clk);
		chk(irq, 1'b0);
		apb(`BPG_IDX_IRQEN, 1, 32'h7);
		repeat (2) @(posedge ref_clk);
		chk(irq, 1'b1);
		apb(`BPG_IDX_IRQCLR, 1, 32'h4);
		repeat (2) @(posedge ref_clk);
		chk(irq, 1'b0);
		waitPk(1);
		nBy = 0;
		apb(`BPG_IDX_STATCTL, 1, 32'h2);
		apb(`BPG_IDX_STATCTL, 0, 32'hFF);
		waitPk(1);
		apb(`BPG_IDX_STATCTL, 1, 32'h1);
		apb(`BPG_IDX_STATCTL, 0, 32'h0);
		apb(`BPG_IDX_BYTECNT, 0, nBy);
		apb(`BPG_IDX_PKTLEN, 1, 32'h8000);
		while (!irq) @(posedge ref_clk);
		apb(`BPG_IDX_STATCTL, 1, 32'h1);
		apb(`BPG_IDX_STATCTL, 0, 32'h200);
		apb(`BPG_IDX_BYTECNT, 0, 32'hFFFF);
		apb(`BPG_IDX_STATCTL, 1, 32'h2);
		apb(`BPG_IDX_STATCTL, 1, 32'h1);
		apb(`BPG_IDX_STATCTL, 0, 32'h0);
		finish_test;
	end
endmodule
